// file: design/psfc_pkg.sv
// Constants, op codes and state type for the program security fuse controller
package psfc_pkg;
    // ==================================================
    // Register addresses
    localparam logic [7:0] FLASH_CTRL_ADDR = 8'hB2;
    localparam logic [15:0] TRIM_PROG_ADDR = 16'hFFD1;
    localparam logic [15:0] FUSE_BURN_ADDR = 16'hFFD2;
    localparam logic [15:0] SEC_STATUS_ADDR = 16'hFFD7;

    // ==================================================
    // Field positions
    localparam int FC_PWE_BIT = 0;
    localparam int FC_MEEN_BIT = 1;
    localparam int FC_SECURE_BIT = 6;
    localparam int SS_L1_BIT = 0;
    localparam int SS_L0_BIT = 1;
    localparam int SS_STRAP_BIT = 5;

    // ==================================================
    // Burn sequence codes
    localparam logic [7:0] FUSE_SETUP_CODE = 8'h54;
    localparam logic [7:0] SEL_L0_CODE = 8'h81;
    localparam logic [7:0] SEL_L1_CODE = 8'h82;
    localparam logic [7:0] BURN_CODE = 8'hA6;

    // ==================================================
    // Reset values
    localparam logic [7:0] RDATA_RESET = 8'h00;
    localparam logic RESET_BIT = 1'b0;

    // ==================================================
    // Flash / debug operation codes
    localparam logic [2:0] OP_FLASH_READ = 3'h0;
    localparam logic [2:0] OP_FLASH_WRITE = 3'h1;
    localparam logic [2:0] OP_PAGE_ERASE = 3'h2;
    localparam logic [2:0] OP_BULK_ERASE = 3'h3;
    localparam logic [2:0] OP_XRAM_READ = 3'h4;
    localparam logic [2:0] OP_CORE_CTRL = 3'h5;

    // ==================================================
    // Burn sequencer states, one-hot
    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_SETUP = 6'h02,
        ST_SEL0 = 6'h04,
        ST_SEL1 = 6'h08,
        ST_BURN0 = 6'h10,
        ST_BURN1 = 6'h20
    } psfc_burn_t;
endpackage : psfc_pkg

// file: design/psfc_program_security_fuse_ctrl.sv
// Program security fuse controller: protect levels, fuse burn sequencer, access gating
`timescale 1ns/1ps

// What this block does
// [R1] Writing bit 6 of flash control at 0xB2 arms protection level 0.
// [R2] Level 0 active: debug port may only bulk erase; all else blocked.
// [R3] Protect bit clears on every reset; software can set it, zero writes ignored.
// [R4] Level 0 leaves on any reset; after a global erase it cannot be re-armed until then; debug regains control.
// [R5] Global flash erase also clears external data RAM, protect bit or not.
// [R6] Level 0 active: external reads of flash and data RAM are denied.
// [R7] Protect bit takes effect only with level 0 fuse blown; fuse at bit 1.
// [R8] Level 0 active: page erase of page zero refused from CPU and debug.
// [R9] Level 0 active: every write to page zero blocked, CPU or debug.
// [R10] Level 1 fuse blown disables debug port at once and for good.
// [R11] Level 1 fuse state is sampled during reset, before boot.
// [R12] Burner holds strap pin high for level 1 burns; level 0 needs not.
// [R13] Live strap pin level reads at bit 5 of security status 0xFFD7.
// [R14] Burn step one: firmware writes 0x54 to fuse burn control.
// [R15] Step two: 0x81 selects level 0, 0x82 level 1; one per sequence.
// [R16] Step three: 0xA6 to trim program control, then wait about 500 us.
// [R17] Final step: 0x00 to both burn registers ends the burn.
// [R18] A blown fuse stays in effect; no write or reset undoes it.
// [R19] Any non-burn value written to the burn register stops burning.
// [R20] Level 1 burn refused while the strap pin reads low.
module psfc_program_security_fuse_ctrl
    import psfc_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // Internal special function register port
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    output logic [7:0] sfr_rdata,
    // Memory-mapped special function register port
    input wire logic [15:0] xsfr_addr,
    input wire logic [7:0] xsfr_wdata,
    input wire logic xsfr_wr,
    input wire logic xsfr_rd,
    output logic [7:0] xsfr_rdata,
    // CPU status inputs
    input wire logic int_enabled,
    input wire logic flash_byte_done,
    // Fuse array and strap pin
    input wire logic level0_fuse,
    input wire logic level1_fuse,
    input wire logic strap_pin_level,
    output logic burn_level0,
    output logic burn_level1,
    // In-circuit debug port requests
    input wire logic dbg_req,
    input wire logic [2:0] dbg_op,
    input wire logic dbg_page0,
    output logic dbg_grant,
    output logic dbg_deny,
    // CPU flash requests
    input wire logic cpu_req,
    input wire logic [2:0] cpu_op,
    input wire logic cpu_page0,
    output logic cpu_grant,
    output logic cpu_deny,
    // Protection state and erase side effects
    output logic level0_active,
    output logic debug_disabled,
    output logic program_write_en,
    output logic xram_clear
);

    // ==================================================
    // State registers
    logic secure_r;
    logic pwe_r;
    logic meen_r;
    logic erased_r;
    logic l0_blown_r;
    logic l1_blown_r;
    logic l0_active_r;
    logic dbg_off_r;
    logic burn_l0_r;
    logic burn_l1_r;
    logic dbg_grant_r;
    logic dbg_deny_r;
    logic cpu_grant_r;
    logic cpu_deny_r;
    logic xram_clear_r;
    logic [7:0] sfr_rdata_r;
    logic [7:0] xsfr_rdata_r;
    psfc_burn_t state_r;
    psfc_burn_t state_nxt;

    // ==================================================
    // Address decode
    wire fc_wr = sfr_wr & (sfr_addr == FLASH_CTRL_ADDR);
    wire fc_rd = sfr_rd & (sfr_addr == FLASH_CTRL_ADDR);
    wire trim_wr = xsfr_wr & (xsfr_addr == TRIM_PROG_ADDR);
    wire fuse_wr = xsfr_wr & (xsfr_addr == FUSE_BURN_ADDR);
    wire ss_rd = xsfr_rd & (xsfr_addr == SEC_STATUS_ADDR);

    // ==================================================
    // Fuse sampling: the fuse level is taken during reset as well, so the
    // debug port is already closed when boot code starts running
    wire l0_blown_nxt = l0_blown_r | level0_fuse; // [R18]
    wire l1_blown_nxt = l1_blown_r | level1_fuse; // [R18]

    // Level 0 is the protect bit gated by its fuse
    wire sec_act = secure_r & l0_blown_r; // [R7]

    // Protect bit: set-only, and refused after a global erase until the
    // next reset, so the erased part always comes up unlocked
    wire secure_set = fc_wr & sfr_wdata[FC_SECURE_BIT] & l0_blown_r & ~erased_r; // [R1] [R4] [R7]
    wire secure_nxt = secure_r | secure_set; // [R3]

    // Write enable follows the bus bit only while interrupts are off,
    // and drops after every flash byte
    wire pwe_wr = fc_wr & ~int_enabled;
    wire pwe_nxt = flash_byte_done ? 1'b0 : (pwe_wr ? sfr_wdata[FC_PWE_BIT] : pwe_r);

    // ==================================================
    // Access gating for debug port and CPU
    wire dbg_is_bulk = (dbg_op == OP_BULK_ERASE);
    wire cpu_is_bulk = (cpu_op == OP_BULK_ERASE);
    wire dbg_is_mod = (dbg_op == OP_FLASH_WRITE) | (dbg_op == OP_PAGE_ERASE);
    wire cpu_is_mod = (cpu_op == OP_FLASH_WRITE) | (cpu_op == OP_PAGE_ERASE);

    // Debug port: nothing once level 1 is set, only bulk erase under level 0;
    // this also shuts out reads of flash and data RAM
    wire dbg_lvl0_ok = ~sec_act | dbg_is_bulk; // [R2] [R6]
    wire dbg_pg0_ok = ~(sec_act & dbg_page0 & dbg_is_mod); // [R8] [R9]
    wire dbg_ok = ~l1_blown_r & dbg_lvl0_ok & dbg_pg0_ok; // [R10]

    // CPU: page zero is locked against writes and page erase under level 0;
    // bulk erase needs the mass erase enable and a live debug port
    wire cpu_pg0_ok = ~(sec_act & cpu_page0 & cpu_is_mod); // [R8] [R9]
    wire cpu_bulk_ok = ~cpu_is_bulk | (meen_r & ~l1_blown_r);
    wire cpu_ok = cpu_pg0_ok & cpu_bulk_ok;

    wire dbg_bulk_go = dbg_req & dbg_ok & dbg_is_bulk;
    wire cpu_bulk_go = cpu_req & cpu_ok & cpu_is_bulk;
    wire bulk_go = dbg_bulk_go | cpu_bulk_go;

    // Mass erase enable is single shot: consumed by the erase it arms
    wire meen_nxt = cpu_bulk_go ? 1'b0 : (fc_wr ? sfr_wdata[FC_MEEN_BIT] : meen_r);

    // ==================================================
    // Burn sequencer decode
    wire is_setup = fuse_wr & (xsfr_wdata == FUSE_SETUP_CODE); // [R14]
    wire is_sel0 = fuse_wr & (xsfr_wdata == SEL_L0_CODE); // [R15]
    wire is_sel1 = fuse_wr & (xsfr_wdata == SEL_L1_CODE); // [R15]
    wire is_burn = trim_wr & (xsfr_wdata == BURN_CODE); // [R16]
    wire stop_burn = (trim_wr & ~is_burn) | fuse_wr; // [R17] [R19]

    // Next state of the burn sequencer; a second select write in a selected
    // state drops back to idle, so only one level is burned per sequence
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ST_IDLE: begin
                if (is_setup) begin
                    state_nxt = ST_SETUP;
                end
            end
            ST_SETUP: begin
                if (is_sel0) begin
                    state_nxt = ST_SEL0;
                end else if (is_sel1) begin
                    state_nxt = ST_SEL1;
                end else if (fuse_wr | trim_wr) begin
                    state_nxt = ST_IDLE;
                end
            end
            ST_SEL0: begin
                if (is_burn) begin
                    state_nxt = ST_BURN0;
                end else if (fuse_wr | trim_wr) begin
                    state_nxt = ST_IDLE;
                end
            end
            ST_SEL1: begin
                if (is_burn & strap_pin_level) begin
                    state_nxt = ST_BURN1; // [R20]
                end else if (fuse_wr | trim_wr) begin
                    state_nxt = ST_IDLE;
                end
            end
            ST_BURN0: begin
                if (stop_burn) begin
                    state_nxt = ST_IDLE; // [R19]
                end
            end
            ST_BURN1: begin
                // A falling strap pin ends a level 1 burn at once
                if (stop_burn | ~strap_pin_level) begin
                    state_nxt = ST_IDLE; // [R19] [R20]
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    // ==================================================
    // Read data: strap pin is sampled at read time, never latched
    wire [7:0] fc_view = {1'b0, secure_r, 4'h0, 1'b0, pwe_r}; // [R1]
    wire [7:0] ss_view = {2'h0, strap_pin_level, 3'h0, l0_blown_r, l1_blown_r}; // [R7] [R13]
    wire [7:0] sfr_rd_nxt = fc_rd ? fc_view : RDATA_RESET;
    wire [7:0] xsfr_rd_nxt = ss_rd ? ss_view : RDATA_RESET;

    // ==================================================
    // Fuse state: taken straight from the fuse array during reset and
    // only ever set afterwards
    // Reset loads the array directly: the sticky OR alone would never leave
    // an unknown power-up state, and a blown fuse reloads as blown anyway
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            l0_blown_r <= level0_fuse; // [R11]
            l1_blown_r <= level1_fuse; // [R11]
            dbg_off_r <= level1_fuse; // [R10] [R11]
        end else begin
            l0_blown_r <= l0_blown_nxt; // [R18]
            l1_blown_r <= l1_blown_nxt; // [R18]
            dbg_off_r <= l1_blown_nxt; // [R10]
        end
    end

    // Protect bit and flash control bits
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            secure_r <= RESET_BIT; // [R3]
            pwe_r <= RESET_BIT;
            meen_r <= RESET_BIT;
        end else begin
            secure_r <= secure_nxt;
            pwe_r <= pwe_nxt;
            meen_r <= meen_nxt;
        end
    end

    // Global erase marker and level 0 output
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            erased_r <= RESET_BIT; // [R4]
            l0_active_r <= RESET_BIT;
        end else begin
            erased_r <= erased_r | bulk_go; // [R4]
            l0_active_r <= secure_nxt & l0_blown_nxt; // [R7]
        end
    end

    // Burn sequencer and burn drive outputs
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state_r <= ST_IDLE;
            burn_l0_r <= RESET_BIT;
            burn_l1_r <= RESET_BIT;
        end else begin
            state_r <= state_nxt;
            burn_l0_r <= (state_nxt == ST_BURN0); // [R16]
            burn_l1_r <= (state_nxt == ST_BURN1); // [R16] [R20]
        end
    end

    // Access answers, one cycle after the request
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            dbg_grant_r <= RESET_BIT;
            dbg_deny_r <= RESET_BIT;
            cpu_grant_r <= RESET_BIT;
            cpu_deny_r <= RESET_BIT;
        end else begin
            dbg_grant_r <= dbg_req & dbg_ok; // [R2]
            dbg_deny_r <= dbg_req & ~dbg_ok; // [R6] [R10]
            cpu_grant_r <= cpu_req & cpu_ok;
            cpu_deny_r <= cpu_req & ~cpu_ok; // [R8] [R9]
        end
    end

    // Data RAM wipe pulse and read data
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            xram_clear_r <= RESET_BIT;
            sfr_rdata_r <= RDATA_RESET;
            xsfr_rdata_r <= RDATA_RESET;
        end else begin
            xram_clear_r <= bulk_go; // [R5]
            sfr_rdata_r <= sfr_rd_nxt;
            xsfr_rdata_r <= xsfr_rd_nxt; // [R13]
        end
    end

    // ==================================================
    // Outputs, each straight from a flip-flop
    assign sfr_rdata = sfr_rdata_r;
    assign xsfr_rdata = xsfr_rdata_r;
    assign burn_level0 = burn_l0_r;
    assign burn_level1 = burn_l1_r;
    assign dbg_grant = dbg_grant_r;
    assign dbg_deny = dbg_deny_r;
    assign cpu_grant = cpu_grant_r;
    assign cpu_deny = cpu_deny_r;
    assign level0_active = l0_active_r;
    assign debug_disabled = dbg_off_r;
    assign program_write_en = pwe_r;
    assign xram_clear = xram_clear_r;

endmodule : psfc_program_security_fuse_ctrl

// file: tb/psfc_checker.sv
// Port-level checks of the program security fuse controller
`timescale 1ns/1ps
// ==================================================
// Checker
module psfc_checker
    import psfc_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // Fuse, strap and burn
    input wire logic level1_fuse,
    input wire logic strap_pin_level,
    input wire logic xsfr_wr,
    input wire logic [15:0] xsfr_addr,
    input wire logic [7:0] xsfr_wdata,
    input wire logic burn_level0,
    input wire logic burn_level1,
    // Debug and CPU gating
    input wire logic dbg_req,
    input wire logic [2:0] dbg_op,
    input wire logic dbg_grant,
    input wire logic dbg_deny,
    input wire logic cpu_req,
    input wire logic [2:0] cpu_op,
    input wire logic cpu_page0,
    input wire logic cpu_deny,
    // Protection state
    input wire logic level0_active,
    input wire logic debug_disabled,
    input wire logic xram_clear
);
    // Single domain; reset masks every check
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    // Protect level: cleared by reset, otherwise it never drops
    property p_l0_reset; $fell(reset) |-> !level0_active; endproperty
    a_l0_reset: assert property (p_l0_reset) else $error("protect level on after reset");
    property p_l0_keep; level0_active |=> level0_active; endproperty
    a_l0_keep: assert property (p_l0_keep) else $error("protect level dropped");
    // Debug and CPU gating; a fuse blown in the same cycle does not yet deny, excluding it only narrows the check
    property p_dbg_l0; dbg_req && level0_active && dbg_op != OP_BULK_ERASE
        |=> dbg_deny && !dbg_grant; endproperty
    a_dbg_l0: assert property (p_dbg_l0) else $error("debug op passed level 0");
    property p_dbg_l1; dbg_req && debug_disabled |=> dbg_deny && !dbg_grant; endproperty
    a_dbg_l1: assert property (p_dbg_l1) else $error("debug op passed level 1");
    property p_erase; dbg_req && dbg_op == OP_BULK_ERASE && !debug_disabled && !level1_fuse
        |=> dbg_grant && xram_clear; endproperty
    a_erase: assert property (p_erase) else $error("bulk erase without data clear");
    property p_cpu_pg0; cpu_req && cpu_page0 && level0_active
        && (cpu_op == OP_FLASH_WRITE || cpu_op == OP_PAGE_ERASE) |=> cpu_deny; endproperty
    a_cpu_pg0: assert property (p_cpu_pg0) else $error("page zero change passed");
    property p_l1_keep; level1_fuse || debug_disabled |=> debug_disabled; endproperty
    a_l1_keep: assert property (p_l1_keep) else $error("debug port came back");
    // Burn sequencer
    property p_one; !(burn_level0 && burn_level1); endproperty
    a_one: assert property (p_one) else $error("two fuses burning");
    property p_stop; xsfr_wr && xsfr_addr == TRIM_PROG_ADDR && xsfr_wdata != BURN_CODE
        |=> !burn_level0 && !burn_level1; endproperty
    a_stop: assert property (p_stop) else $error("burn kept after stop value");
    property p_strap; xsfr_wr && xsfr_addr == TRIM_PROG_ADDR && !strap_pin_level
        |=> !burn_level1; endproperty
    a_strap: assert property (p_strap) else $error("level 1 burn with strap low");
endmodule : psfc_checker

// file: tb/psfc_debug_host.sv
// Model of the external debug host on the debug request port
`timescale 1ns/1ps
// ==================================================
// Debug host
module psfc_debug_host
    import psfc_pkg::*;
(
    // Clock
    input wire logic ref_clk,
    // Request side
    output logic dbg_req,
    output logic [2:0] dbg_op,
    output logic dbg_page0,
    // Answer side
    input wire logic dbg_grant,
    input wire logic dbg_deny
);
    // Idle lines; the op code is junk while no request is up
    initial begin
        dbg_req = 1'b0;
        dbg_op = 3'h7;
        dbg_page0 = 1'b0;
    end
    // One request held to its taking edge; bulk erase is the host's way out of level 0
    task automatic issue(input logic [2:0] op, input logic pg, output logic g, output logic d);
        @(posedge ref_clk);
        #1;
        dbg_req = 1'b1;
        dbg_op = op;
        dbg_page0 = pg;
        @(posedge ref_clk);
        #1;
        g = dbg_grant;
        d = dbg_deny;
        dbg_req = 1'b0;
        dbg_op = ~op; // Released lines show the inverse so a stale value never matches
        dbg_page0 = ~pg;
    endtask : issue
endmodule : psfc_debug_host

// file: tb/psfc_program_security_fuse_ctrl_bench.sv
// Self-checking bench for the program security fuse controller
`timescale 1ns/1ps
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin err_total++; \
    $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end
// ==================================================
// Bench top
module psfc_program_security_fuse_ctrl_bench
    import psfc_pkg::*;
;
    // Stimulus, observed outputs and bookkeeping
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic sfr_wr = 1'b0, sfr_rd = 1'b0, xsfr_wr = 1'b0, xsfr_rd = 1'b0;
    logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, xsfr_wdata = 8'h00;
    logic [15:0] xsfr_addr = 16'h0000;
    logic level0_fuse = 1'b0, level1_fuse = 1'b0, strap_pin_level = 1'b1;
    logic cpu_req = 1'b0, cpu_page0 = 1'b0;
    logic [2:0] cpu_op = 3'h0, dbg_op;
    logic [7:0] sfr_rdata, xsfr_rdata, rd;
    logic burn_level0, burn_level1, dbg_req, dbg_page0, dbg_grant, dbg_deny, g, d;
    logic cpu_grant, cpu_deny, level0_active, debug_disabled, xram_clear, program_write_en;
    int err_total = 0, checks_done = 0, cycles = 0;
    // 100 MHz clock
    initial begin
        forever #5 ref_clk = ~ref_clk;
    end
    // Device and debug host; interrupt and byte-done inputs stay quiet
    psfc_program_security_fuse_ctrl u_dut (
        .ref_clk(ref_clk), .reset(reset),
        .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
        .sfr_rdata(sfr_rdata), .xsfr_addr(xsfr_addr), .xsfr_wdata(xsfr_wdata),
        .xsfr_wr(xsfr_wr), .xsfr_rd(xsfr_rd), .xsfr_rdata(xsfr_rdata),
        .int_enabled(1'b0), .flash_byte_done(1'b0), .level0_fuse(level0_fuse),
        .level1_fuse(level1_fuse), .strap_pin_level(strap_pin_level),
        .burn_level0(burn_level0), .burn_level1(burn_level1), .dbg_req(dbg_req),
        .dbg_op(dbg_op), .dbg_page0(dbg_page0), .dbg_grant(dbg_grant), .dbg_deny(dbg_deny),
        .cpu_req(cpu_req), .cpu_op(cpu_op), .cpu_page0(cpu_page0), .cpu_grant(cpu_grant),
        .cpu_deny(cpu_deny), .level0_active(level0_active), .debug_disabled(debug_disabled),
        .program_write_en(program_write_en), .xram_clear(xram_clear)
    );
    psfc_debug_host u_host (.ref_clk(ref_clk), .dbg_req(dbg_req), .dbg_op(dbg_op),
        .dbg_page0(dbg_page0), .dbg_grant(dbg_grant), .dbg_deny(dbg_deny));
    // Register access on either port; read data lands one cycle after the strobe
    task automatic acc(input bit ext, input bit wr, input logic [15:0] a, input logic [7:0] v);
        @(posedge ref_clk);
        #1;
        if (ext) begin
            {xsfr_wr, xsfr_rd, xsfr_addr, xsfr_wdata} = {wr, !wr, a, v};
        end else begin
            {sfr_wr, sfr_rd, sfr_addr, sfr_wdata} = {wr, !wr, a[7:0], v};
        end
        @(posedge ref_clk);
        #1;
        rd = ext ? xsfr_rdata : sfr_rdata;
        {sfr_wr, sfr_rd, xsfr_wr, xsfr_rd} = 4'h0;
        sfr_wdata = ~v;
        xsfr_wdata = ~v;
    endtask : acc
    // CPU flash request, answer one cycle later
    task automatic cpu(input logic [2:0] op, input logic pg);
        @(posedge ref_clk);
        #1;
        {cpu_req, cpu_op, cpu_page0} = {1'b1, op, pg};
        @(posedge ref_clk);
        #1;
        {g, d} = {cpu_grant, cpu_deny};
        {cpu_req, cpu_op, cpu_page0} = {1'b0, ~op, ~pg};
    endtask : cpu
    // Firmware burn steps up to the burn command; the wait is firmware's own
    task automatic burn(input logic [7:0] sel);
        acc(1, 1, FUSE_BURN_ADDR, FUSE_SETUP_CODE);
        acc(1, 1, FUSE_BURN_ADDR, sel);
        acc(1, 1, TRIM_PROG_ADDR, BURN_CODE);
    endtask : burn
    // One-edge synchronous reset in mid-run
    task automatic pulse_reset();
        @(posedge ref_clk);
        #1;
        reset = 1'b1;
        @(posedge ref_clk);
        #1;
        reset = 1'b0;
    endtask : pulse_reset
    // Report and end the run
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : give_verdict
    // Hang guard, far above the hundred or so cycles the tests need
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 3000) begin
            err_total++;
            give_verdict();
        end
    end
    // ==================================================
    // Test sequence
    initial begin
        repeat (20) @(posedge ref_clk);
        #1;
        reset = 1'b0;
        acc(1, 0, SEC_STATUS_ADDR, 8'h00);
        `CHK(rd, 8'h20)
        acc(0, 1, {8'h00, FLASH_CTRL_ADDR}, 8'h40);
        `CHK(level0_active, 1'b0)
        u_host.issue(OP_FLASH_READ, 1'b0, g, d);
        `CHK({g, d}, 2'b10)
        // Level 0 fuse blown: arm, then try to clear with a zero write
        level0_fuse = 1'b1;
        acc(1, 0, SEC_STATUS_ADDR, 8'h00);
        `CHK(rd, 8'h22)
        acc(0, 1, {8'h00, FLASH_CTRL_ADDR}, 8'h40);
        `CHK(level0_active, 1'b1)
        acc(0, 1, {8'h00, FLASH_CTRL_ADDR}, 8'h00);
        `CHK(level0_active, 1'b1)
        // Read back flash control with the write enable raised as well
        acc(0, 1, {8'h00, FLASH_CTRL_ADDR}, 8'h41);
        acc(0, 0, {8'h00, FLASH_CTRL_ADDR}, 8'h00);
        `CHK({program_write_en, rd}, 9'h141)
        for (int op = 0; op < 6; op++) begin
            if (op != 3) begin
                u_host.issue(3'(op), 1'b0, g, d);
                `CHK({g, d}, 2'b01)
            end
        end
        cpu(OP_FLASH_WRITE, 1'b1);
        `CHK({g, d}, 2'b01)
        cpu(OP_PAGE_ERASE, 1'b1);
        `CHK({g, d}, 2'b01)
        u_host.issue(OP_BULK_ERASE, 1'b0, g, d);
        `CHK({g, d, xram_clear, level0_active}, 4'h0b)
        pulse_reset();
        `CHK(level0_active, 1'b0)
        u_host.issue(OP_CORE_CTRL, 1'b0, g, d);
        `CHK({g, d}, 2'b10)
        u_host.issue(OP_BULK_ERASE, 1'b0, g, d);
        `CHK({g, d, xram_clear}, 3'b101)
        // After an erase the protect bit stays refused until reset; page zero is open
        acc(0, 1, {8'h00, FLASH_CTRL_ADDR}, 8'h40);
        `CHK(level0_active, 1'b0)
        cpu(OP_FLASH_WRITE, 1'b1);
        `CHK({g, d}, 2'b10)
        // Burns: level 0, level 1 refused on a low strap, then stopped by other values
        burn(SEL_L0_CODE);
        `CHK({burn_level0, burn_level1}, 2'b10)
        acc(1, 1, TRIM_PROG_ADDR, 8'h00);
        `CHK({burn_level0, burn_level1}, 2'b00)
        acc(1, 1, FUSE_BURN_ADDR, 8'h00);
        strap_pin_level = 1'b0;
        burn(SEL_L1_CODE);
        `CHK(burn_level1, 1'b0)
        strap_pin_level = 1'b1;
        burn(SEL_L1_CODE);
        `CHK({burn_level0, burn_level1}, 2'b01)
        acc(1, 1, TRIM_PROG_ADDR, 8'h11);
        `CHK(burn_level1, 1'b0)
        acc(1, 1, FUSE_BURN_ADDR, 8'h00);
        // Level 1 fuse: debug port gone, through a reset too
        level1_fuse = 1'b1;
        u_host.issue(OP_BULK_ERASE, 1'b0, g, d);
        `CHK({g, d, debug_disabled}, 3'b011)
        pulse_reset();
        `CHK(debug_disabled, 1'b1)
        acc(1, 0, SEC_STATUS_ADDR, 8'h00);
        `CHK(rd, 8'h23)
        give_verdict();
    end
endmodule : psfc_program_security_fuse_ctrl_bench
// Checker attached to every controller instance
bind psfc_program_security_fuse_ctrl psfc_checker u_chk (.ref_clk(ref_clk), .reset(reset),
    .level1_fuse(level1_fuse), .strap_pin_level(strap_pin_level), .xsfr_wr(xsfr_wr),
    .xsfr_addr(xsfr_addr), .xsfr_wdata(xsfr_wdata), .burn_level0(burn_level0),
    .burn_level1(burn_level1), .dbg_req(dbg_req), .dbg_op(dbg_op), .dbg_grant(dbg_grant),
    .dbg_deny(dbg_deny), .cpu_req(cpu_req), .cpu_op(cpu_op), .cpu_page0(cpu_page0),
    .cpu_deny(cpu_deny), .level0_active(level0_active), .debug_disabled(debug_disabled),
    .xram_clear(xram_clear));
